/* File: hw/pmc_pkg.sv */
// Shared constants and types for the power mode controller
package pmc_pkg;
    localparam int       PORT_W     = 8;
    localparam int       IRQ_W      = 8;
    localparam int       DIV_W      = 6;
    localparam int       SEL_W      = 3;
    localparam logic [2:0] SEL_SLOW   = 3'h7;
    localparam logic [2:0] SEL_RESET  = 3'h7;
    localparam logic [2:0] SEL_DIV1   = 3'h0;
    localparam logic [7:0] PORT_RESET = 8'hff;
    localparam logic [7:0] IRQ_RESET  = 8'h00;
    localparam logic [5:0] DIV_RESET  = 6'h00;

    typedef enum logic [2:0] {
        MODE_FAST, MODE_SLOW, MODE_SLEEP, MODE_IDLE_SUB_ONLY_MODE, MODE_IDLE_BOTH_CLOCKS_MODE, MODE_IDLE_FAST_ONLY_MODE
    } op_mode_t;

    typedef enum logic [1:0] {ST_RUN, ST_HALTED, ST_WAKE_WAIT} pm_state_t;

    typedef enum logic [1:0] {
        CAUSE_RESUME, CAUSE_IRQ, CAUSE_WDT
    } wake_cause_t;
endpackage : pmc_pkg

/* File: hw/clk_sel_if.sv */
// Clock source selection signals between controller and switch
interface clk_sel_if;
    logic want_slow;
    logic hold;
    logic active_slow;
    logic busy;
    modport ctrl (output want_slow, output hold, input active_slow, input busy);
    modport mux  (input want_slow, input hold, output active_slow, output busy);
endinterface : clk_sel_if

/* File: hw/clock_divider.sv */
// High-speed clock enable divider, ratio 1 to 64
module clock_divider
    import pmc_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             fast_tick,
    input  wire logic [SEL_W-1:0] ratio_sel,
    output logic                  div_tick
);
    logic [DIV_W-1:0] count;
    logic [DIV_W-1:0] next_count;
    logic [DIV_W-1:0] mask;
    logic             next_div_tick;

    always_comb begin
        mask          = DIV_W'((7'h01 << ratio_sel) - 7'h01);
        next_count    = fast_tick ? count + 6'h01 : count;
        next_div_tick = fast_tick && ((count & mask) == DIV_RESET);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count    <= DIV_RESET;
            div_tick <= 1'b0;
        end else begin
            count    <= next_count;
            div_tick <= next_div_tick;
        end
    end
endmodule : clock_divider

/* File: hw/glitch_free_mux.sv */
// Glitch-free switch between divided fast clock and sub clock
module glitch_free_mux
    import pmc_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic fast_div_tick,
    input  wire logic sub_tick,
    clk_sel_if.mux    sel,
    output logic      sys_tick
);
    logic cur_slow;
    logic next_cur_slow;
    logic pend;
    logic next_pend;
    logic next_sys_tick;

    // Old source stops at once; new one is taken on its own edge
    always_comb begin
        next_pend     = (sel.want_slow != cur_slow);
        next_cur_slow = cur_slow;
        if (pend && (sel.want_slow ? sub_tick : fast_div_tick)) begin
            next_cur_slow = sel.want_slow;
        end
        next_sys_tick = !sel.hold && !next_pend && !pend
                      && (cur_slow ? sub_tick : fast_div_tick);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_slow <= 1'b1;
            pend     <= 1'b0;
            sys_tick <= 1'b0;
        end else begin
            cur_slow <= next_cur_slow;
            pend     <= next_pend;
            sys_tick <= next_sys_tick;
        end
    end

    assign sel.active_slow = cur_slow;
    assign sel.busy        = pend;

    property p_switch_gap;
        @(posedge clk) disable iff (!rst_n)
        $changed(cur_slow) |-> !sys_tick ##1 !sys_tick;
    endproperty
    a_switch_gap: assert property (p_switch_gap) else $error("tick during switch");
endmodule : glitch_free_mux

/* File: hw/power_mode_controller.sv */
// Power and operating mode controller: clock select, halt modes, wake-up
module power_mode_controller (
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    input  wire logic [pmc_pkg::SEL_W-1:0]    system_clock_select,
    input  wire logic                         fast_osc_keep_on_stop,
    input  wire logic                         slow_osc_keep_on_stop,
    input  wire logic                         fast_osc_enable,
    input  wire logic                         fast_osc_ready,
    input  wire logic                         slow_osc_ready,
    input  wire logic                         fast_tick,
    input  wire logic                         sub_tick,
    input  wire logic                         stop_cpu,
    input  wire logic                         clear_watchdog,
    input  wire logic                         watchdog_enabled,
    input  wire logic                         watchdog_overflow,
    input  wire logic                         external_reset_req,
    input  wire logic [pmc_pkg::PORT_W-1:0]   port_a_pins,
    input  wire logic [pmc_pkg::PORT_W-1:0]   port_a_wake_enable,
    input  wire logic [pmc_pkg::IRQ_W-1:0]    irq_request,
    input  wire logic [pmc_pkg::IRQ_W-1:0]    irq_enable,
    input  wire logic                         stack_full,
    output logic                              sys_clk_en,
    output logic                              fast_clk_en,
    output logic                              sub_clk_en,
    output logic                              fast_osc_run,
    output logic                              slow_osc_run,
    output logic                              fast_osc_stable_flag,
    output pmc_pkg::op_mode_t                 op_mode,
    output logic                              cpu_halted,
    output logic                              power_down_flag,
    output logic                              watchdog_timeout_flag,
    output logic                              watchdog_clear,
    output logic                              watchdog_run,
    output logic                              full_reset_req,
    output logic                              watchdog_reset_req,
    output logic                              interrupt_response,
    output logic                              resume_next
);
    import pmc_pkg::*;

    clk_sel_if sel_if ();

    logic        div_tick;
    logic [SEL_W-1:0] ratio_sel;

    pm_state_t   state, next_state;
    wake_cause_t cause, next_cause;
    logic        keep_fast, next_keep_fast;
    logic        keep_slow, next_keep_slow;
    logic [IRQ_W-1:0]  irq_armed, next_irq_armed;
    logic [PORT_W-1:0] pa_prev;
    logic [PORT_W-1:0] pa_fall;
    logic        want_slow, next_want_slow;
    logic        hold, next_hold;
    logic        halted;
    logic        osc_ok;
    logic        pin_wake;
    logic        irq_wake;
    logic        irq_serve;

    logic        next_fast_clk_en, next_sub_clk_en;
    logic        next_fast_run, next_slow_run, next_fast_flag;
    op_mode_t    next_op_mode;
    logic        next_cpu_halted, next_pdf, next_tof;
    logic        next_wdt_clear, next_wdt_run;
    logic        next_full_reset, next_wdt_reset;
    logic        next_irq_resp, next_resume;

    // Slow selection feeds divider ratio 1 so divider stays defined
    assign ratio_sel = (system_clock_select == SEL_SLOW) ? SEL_DIV1
                                                          : system_clock_select;

    clock_divider u_div (
        .clk       (clk),
        .rst_n     (rst_n),
        .fast_tick (fast_tick),
        .ratio_sel (ratio_sel),
        .div_tick  (div_tick)
    );

    glitch_free_mux u_mux (
        .clk           (clk),
        .rst_n         (rst_n),
        .fast_div_tick (div_tick),
        .sub_tick      (sub_tick),
        .sel           (sel_if.mux),
        .sys_tick      (sys_clk_en)
    );

    assign sel_if.want_slow = want_slow;
    assign sel_if.hold      = hold;

    // Wake source detection and oscillator status
    always_comb begin
        halted    = (state != ST_RUN);
        pa_fall   = pa_prev & ~port_a_pins;
        pin_wake  = |(pa_fall & port_a_wake_enable);
        irq_wake  = |(irq_request & irq_armed);
        irq_serve = |(irq_request & irq_armed & irq_enable) && !stack_full;
        osc_ok    = sel_if.active_slow ? slow_osc_ready : fast_osc_stable_flag;
    end

    // Mode sequencing
    always_comb begin
        next_state      = state;
        next_cause      = cause;
        next_keep_fast  = keep_fast;
        next_keep_slow  = keep_slow;
        next_irq_armed  = irq_armed;
        next_pdf        = power_down_flag;
        next_tof        = watchdog_timeout_flag;
        next_wdt_clear  = 1'b0;
        next_full_reset = 1'b0;
        next_wdt_reset  = 1'b0;
        next_irq_resp   = 1'b0;
        next_resume     = 1'b0;
        unique case (state)
            ST_RUN: begin
                if (clear_watchdog) begin
                    next_pdf       = 1'b0;
                    next_wdt_clear = 1'b1;
                end
                if (watchdog_overflow) begin
                    next_tof       = 1'b1;
                    next_wdt_reset = 1'b1;
                end
                if (stop_cpu) begin
                    next_state     = ST_HALTED;
                    next_keep_fast = fast_osc_keep_on_stop;
                    next_keep_slow = slow_osc_keep_on_stop;
                    next_irq_armed = ~irq_request;
                    next_pdf       = 1'b1;
                    next_tof       = watchdog_overflow; // Overflow in same cycle wins
                    next_wdt_clear = 1'b1;
                end
            end
            ST_HALTED: begin
                if (external_reset_req) begin
                    next_full_reset = 1'b1;
                    next_state      = ST_RUN;
                end else if (watchdog_overflow) begin
                    next_tof   = 1'b1;
                    next_cause = CAUSE_WDT;
                    next_state = ST_WAKE_WAIT;
                end else if (pin_wake) begin
                    next_cause = CAUSE_RESUME;
                    next_state = ST_WAKE_WAIT;
                end else if (irq_wake) begin
                    next_cause = irq_serve ? CAUSE_IRQ : CAUSE_RESUME;
                    next_state = ST_WAKE_WAIT;
                end
            end
            ST_WAKE_WAIT: begin
                if (external_reset_req) begin
                    next_full_reset = 1'b1;
                    next_state      = ST_RUN;
                end else if (osc_ok && !sel_if.busy) begin
                    next_state = ST_RUN;
                    unique case (cause)
                        CAUSE_WDT:    next_wdt_reset = 1'b1;
                        CAUSE_IRQ:    next_irq_resp  = 1'b1;
                        CAUSE_RESUME: next_resume    = 1'b1;
                    endcase
                end
            end
        endcase
    end

    // Oscillators, clock gating and selection
    always_comb begin
        next_fast_run  = halted ? (keep_fast || state == ST_WAKE_WAIT)
                                : (fast_osc_enable || system_clock_select != SEL_SLOW);
        next_slow_run  = !halted || keep_slow || watchdog_enabled
                       || (state == ST_WAKE_WAIT);
        next_fast_flag = next_fast_run && fast_osc_run && fast_osc_ready;
        next_fast_clk_en = fast_tick && fast_osc_run
                         && (!halted || keep_fast);
        next_sub_clk_en  = sub_tick && slow_osc_run
                         && (!halted || keep_slow);
        next_want_slow = want_slow;
        if (system_clock_select == SEL_SLOW) begin
            if (slow_osc_ready) begin
                next_want_slow = 1'b1;
            end
        end else if (fast_osc_stable_flag) begin
            next_want_slow = 1'b0;
        end
        next_hold       = (next_state != ST_RUN);
        next_cpu_halted = (next_state != ST_RUN);
        next_wdt_run    = watchdog_enabled;
        if (!halted) begin
            next_op_mode = sel_if.active_slow ? MODE_SLOW : MODE_FAST;
        end else if (keep_fast && keep_slow) begin
            next_op_mode = MODE_IDLE_BOTH_CLOCKS_MODE;
        end else if (keep_fast) begin
            next_op_mode = MODE_IDLE_FAST_ONLY_MODE;
        end else if (keep_slow) begin
            next_op_mode = MODE_IDLE_SUB_ONLY_MODE;
        end else begin
            next_op_mode = MODE_SLEEP;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state                 <= ST_RUN;
            cause                 <= CAUSE_RESUME;
            keep_fast             <= 1'b0;
            keep_slow             <= 1'b0;
            irq_armed             <= IRQ_RESET;
            pa_prev               <= PORT_RESET;
            want_slow             <= 1'b1;
            hold                  <= 1'b0;
            fast_clk_en           <= 1'b0;
            sub_clk_en            <= 1'b0;
            fast_osc_run          <= 1'b0;
            slow_osc_run          <= 1'b1;
            fast_osc_stable_flag  <= 1'b0;
            op_mode               <= MODE_SLOW;
            cpu_halted            <= 1'b0;
            power_down_flag       <= 1'b0;
            watchdog_timeout_flag <= 1'b0;
            watchdog_clear        <= 1'b0;
            watchdog_run          <= 1'b0;
            full_reset_req        <= 1'b0;
            watchdog_reset_req    <= 1'b0;
            interrupt_response    <= 1'b0;
            resume_next           <= 1'b0;
        end else begin
            state                 <= next_state;
            cause                 <= next_cause;
            keep_fast             <= next_keep_fast;
            keep_slow             <= next_keep_slow;
            irq_armed             <= next_irq_armed;
            pa_prev               <= port_a_pins;
            want_slow             <= next_want_slow;
            hold                  <= next_hold;
            fast_clk_en           <= next_fast_clk_en;
            sub_clk_en            <= next_sub_clk_en;
            fast_osc_run          <= next_fast_run;
            slow_osc_run          <= next_slow_run;
            fast_osc_stable_flag  <= next_fast_flag;
            op_mode               <= next_op_mode;
            cpu_halted            <= next_cpu_halted;
            power_down_flag       <= next_pdf;
            watchdog_timeout_flag <= next_tof;
            watchdog_clear        <= next_wdt_clear;
            watchdog_run          <= next_wdt_run;
            full_reset_req        <= next_full_reset;
            watchdog_reset_req    <= next_wdt_reset;
            interrupt_response    <= next_irq_resp;
            resume_next           <= next_resume;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic halt_go;
    assign halt_go = (state == ST_RUN) && stop_cpu;

    property p_enter_flags;
        halt_go |=> power_down_flag && watchdog_clear
                    && (watchdog_timeout_flag == $past(watchdog_overflow));
    endproperty
    a_enter_flags: assert property (p_enter_flags) else $error("halt flags wrong");

    property p_wdt_clear;
        halt_go && watchdog_enabled |=> watchdog_clear ##1 watchdog_run;
    endproperty
    a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog not cleared");

    property p_sleep;
        halt_go && !fast_osc_keep_on_stop && !slow_osc_keep_on_stop
            |=> ##1 op_mode == MODE_SLEEP && !fast_clk_en && !sub_clk_en;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep clocks running");

    property p_idle_sub_only_mode;
        halt_go && !fast_osc_keep_on_stop && slow_osc_keep_on_stop
            |=> ##1 !fast_osc_run && slow_osc_run && op_mode == MODE_IDLE_SUB_ONLY_MODE;
    endproperty
    a_idle_sub_only_mode: assert property (p_idle_sub_only_mode) else $error("idle_sub_only_mode oscillators wrong");

    property p_idle_both_clocks_mode;
        halt_go && fast_osc_keep_on_stop && slow_osc_keep_on_stop
            |=> ##1 fast_osc_run && slow_osc_run && cpu_halted;
    endproperty
    a_idle_both_clocks_mode: assert property (p_idle_both_clocks_mode) else $error("idle_both_clocks_mode oscillators wrong");

    property p_idle_fast_only_mode;
        halt_go && fast_osc_keep_on_stop && !slow_osc_keep_on_stop
            |=> ##1 fast_osc_run && !sub_clk_en && op_mode == MODE_IDLE_FAST_ONLY_MODE;
    endproperty
    a_idle_fast_only_mode: assert property (p_idle_fast_only_mode) else $error("idle_fast_only_mode clocks wrong");

    property p_no_sys_clock;
        (state == ST_HALTED) [*3] |-> !sys_clk_en;
    endproperty
    a_no_sys_clock: assert property (p_no_sys_clock) else $error("cpu clock while halted");

    property p_ext_reset;
        state == ST_HALTED && external_reset_req |=> full_reset_req && state == ST_RUN;
    endproperty
    a_ext_reset: assert property (p_ext_reset) else $error("no full reset on wake");

    property p_wdt_wake;
        state == ST_HALTED && !external_reset_req && watchdog_overflow
            |=> watchdog_timeout_flag && state == ST_WAKE_WAIT;
    endproperty
    a_wdt_wake: assert property (p_wdt_wake) else $error("timeout wake wrong");

    property p_pdf_clear;
        state == ST_RUN && clear_watchdog && !stop_cpu |=> !power_down_flag;
    endproperty
    a_pdf_clear: assert property (p_pdf_clear) else $error("power-down flag kept");

    property p_flag_restart;
        $rose(fast_osc_run) |-> !fast_osc_stable_flag;
    endproperty
    a_flag_restart: assert property (p_flag_restart) else $error("stable flag not cleared");

    property p_slow_ready;
        $rose(want_slow) |-> $past(slow_osc_ready);
    endproperty
    a_slow_ready: assert property (p_slow_ready) else $error("slow switch before ready");

    property p_wake_wait;
        state == ST_WAKE_WAIT && !osc_ok |=> state != ST_RUN || full_reset_req;
    endproperty
    a_wake_wait: assert property (p_wake_wait) else $error("resumed on unstable osc");
endmodule : power_mode_controller

/* File: testbench/pmc_partner.sv */
// Oscillator and tick model facing the power mode controller
module pmc_partner (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic fast_osc_run,
    input  wire logic slow_osc_run,
    output logic      fast_osc_ready,
    output logic      slow_osc_ready,
    output logic      fast_tick,
    output logic      sub_tick
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] fast_age;
    logic [3:0] slow_age;
    logic [2:0] sub_phase;
    // Oscillators settle some cycles after power-up, tick only once stable
    assign fast_osc_ready = fast_age == 4'ha;
    assign slow_osc_ready = slow_age == 4'h6;
    assign fast_tick      = fast_osc_ready;
    assign sub_tick       = slow_osc_ready && sub_phase == 3'h7;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fast_age  <= 4'h0;
            slow_age  <= 4'h0;
            sub_phase <= 3'h0;
        end else begin
            fast_age  <= !fast_osc_run ? 4'h0 : fast_age + {3'h0, !fast_osc_ready};
            slow_age  <= !slow_osc_run ? 4'h0 : slow_age + {3'h0, !slow_osc_ready};
            sub_phase <= slow_osc_ready ? sub_phase + 3'h1 : 3'h0;
        end
    end
endmodule : pmc_partner

/* File: testbench/power_mode_controller_tb.sv */
// Self-checking testbench for the power mode controller
module power_mode_controller_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pmc_pkg::*;
    logic       clk = 1'b0, rst_n = 1'b0;
    logic [2:0] system_clock_select = 3'h7;
    logic       fast_osc_keep_on_stop = 1'b0, slow_osc_keep_on_stop = 1'b0;
    logic       fast_osc_enable = 1'b0, stop_cpu = 1'b0, clear_watchdog = 1'b0;
    logic       watchdog_enabled = 1'b0, watchdog_overflow = 1'b0;
    logic       external_reset_req = 1'b0, stack_full = 1'b0;
    logic [7:0] port_a_pins = 8'hff, port_a_wake_enable = 8'h00;
    logic [7:0] irq_request = 8'h00, irq_enable = 8'h00;
    logic       fast_osc_ready, slow_osc_ready, fast_tick, sub_tick, sys_clk_en;
    logic       fast_clk_en, sub_clk_en, fast_osc_run, slow_osc_run, fast_osc_stable_flag;
    logic       cpu_halted, power_down_flag, watchdog_timeout_flag, watchdog_clear;
    logic       watchdog_run, full_reset_req, watchdog_reset_req;
    logic       interrupt_response, resume_next, was_halted = 1'b0;
    logic       first_halt = 1'b0;
    logic [2:0] entry_flags = 3'h0;
    op_mode_t   op_mode;
    op_mode_t   modes[4] = '{MODE_SLEEP, MODE_IDLE_SUB_ONLY_MODE, MODE_IDLE_FAST_ONLY_MODE, MODE_IDLE_BOTH_CLOCKS_MODE};
    int         bad_count = 0, comparisons = 0;
    logic [5:0] halt_q[$];
    logic [3:0] wake_q[$];

    always #2 clk = ~clk;

    power_mode_controller uut (.clk, .rst_n, .system_clock_select, .fast_osc_keep_on_stop,
        .slow_osc_keep_on_stop, .fast_osc_enable, .fast_osc_ready, .slow_osc_ready,
        .fast_tick, .sub_tick, .stop_cpu, .clear_watchdog, .watchdog_enabled,
        .watchdog_overflow, .external_reset_req, .port_a_pins, .port_a_wake_enable,
        .irq_request, .irq_enable, .stack_full, .sys_clk_en, .fast_clk_en, .sub_clk_en,
        .fast_osc_run, .slow_osc_run, .fast_osc_stable_flag, .op_mode, .cpu_halted,
        .power_down_flag, .watchdog_timeout_flag, .watchdog_clear, .watchdog_run,
        .full_reset_req, .watchdog_reset_req, .interrupt_response, .resume_next);
    pmc_partner partner (.clk, .rst_n, .fast_osc_run, .slow_osc_run, .fast_osc_ready,
        .slow_osc_ready, .fast_tick, .sub_tick);

    task automatic fail(input string m);
        bad_count++;
        $display("[FAIL] %0t %s", $time, m);
    endtask : fail
    task automatic chk_val(input logic [8:0] got, input logic [8:0] exp);
        comparisons++;
        if (got !== exp) fail($sformatf("value %h, expected %h", got, exp));
    endtask : chk_val
    task automatic chk_cnt(input int got, input int exp);
        comparisons++;
        if (got < exp - 1 || got > exp + 1) fail($sformatf("%0d ticks, expected %0d", got, exp));
    endtask : chk_cnt
    task automatic chk_halt(input logic [5:0] got);
        comparisons++;
        if (halt_q.size() == 0) fail("unexpected halt");
        else if (got !== halt_q.pop_front()) fail("halt entry state wrong");
    endtask : chk_halt
    task automatic chk_wake(input logic [3:0] got);
        comparisons++;
        if (wake_q.size() == 0) fail("unexpected wake");
        else if (got !== wake_q.pop_front()) fail("wrong wake response");
    endtask : chk_wake

    // Monitor: halt entry and wake pulses against the queued notes
    // Mode settles one cycle after the entry flags, so it is taken an edge later
    always @(posedge clk) begin
        if (rst_n && first_halt && cpu_halted === 1'b1)
            chk_halt({op_mode, entry_flags});
        first_halt  <= rst_n && cpu_halted === 1'b1 && was_halted !== 1'b1;
        entry_flags <= {power_down_flag, watchdog_timeout_flag, watchdog_clear};
        if (rst_n && (full_reset_req | watchdog_reset_req | interrupt_response | resume_next))
            chk_wake({full_reset_req, watchdog_reset_req, interrupt_response, resume_next});
        was_halted <= cpu_halted;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic halt(input logic fk, input logic sk, input op_mode_t m);
        fast_osc_keep_on_stop = fk;
        slow_osc_keep_on_stop = sk;
        halt_q.push_back({m, 3'h5});
        stop_cpu = 1'b1;
        tick(1);
        stop_cpu = 1'b0;
        tick(4);
    endtask : halt
    task automatic wait_run(input logic [3:0] exp);
        int n = 0;
        wake_q.push_back(exp);
        while (cpu_halted === 1'b1 && n < 100) begin
            tick(1);
            n++;
        end
        if (cpu_halted !== 1'b0) fail("no wake");
        tick(2);
    endtask : wait_run
    task automatic rate(input logic [2:0] s);
        int n = 0;
        system_clock_select = s;
        tick(60);
        for (int i = 0; i < 256; i++) begin
            if (sys_clk_en === 1'b1) n++;
            tick(1);
        end
        chk_val(op_mode, s == 3'h7 ? MODE_SLOW : MODE_FAST);
        chk_cnt(n, s == 3'h7 ? 32 : 256 >> s);
    endtask : rate
    task automatic final_report();
        if (halt_q.size() != 0 || wake_q.size() != 0) fail("expected result never seen");
        $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : final_report

    initial begin
        #60000;
        fail("watchdog expired");
        final_report();
    end

    initial begin
        int p;
        logic [7:0] ib[3] = '{8'h01, 8'h02, 8'h20};
        void'($urandom(7));
        repeat (3) @(posedge clk);
        #1 rst_n = 1'b1;
        tick(20);
        chk_val(fast_osc_stable_flag, 1'b0);
        fast_osc_enable = 1'b1;
        tick(3);
        chk_val(fast_osc_stable_flag, 1'b0);
        tick(30);
        chk_val(fast_osc_stable_flag, 1'b1);
        // Fast oscillator off in slow mode, so the first fast select restarts it
        fast_osc_enable = 1'b0;
        for (int s = 0; s < 8; s++) rate(s[2:0]);
        $display("test clock select done");
        for (int k = 0; k < 4; k++) begin
            p = $urandom_range(7, 0);
            watchdog_enabled = 1'($urandom);
            halt(k[1], k[0], modes[k]);
            port_a_wake_enable = 8'h01 << p;
            port_a_pins = ~(8'h01 << ((p + 1) % 8));
            tick(10);
            chk_val(cpu_halted, 1'b1);
            chk_val({fast_osc_run, slow_osc_run, watchdog_run},
                    {k[1], k[0] | watchdog_enabled, watchdog_enabled});
            port_a_pins = ~(8'h01 << p);
            wait_run(4'h1);
            port_a_pins = 8'hff;
        end
        $display("test halt modes done");
        irq_enable = 8'h0f;
        for (int j = 0; j < 3; j++) begin
            stack_full = j == 1;
            halt(1'b1, 1'b1, MODE_IDLE_BOTH_CLOCKS_MODE);
            irq_request = ib[j];
            wait_run(j == 0 ? 4'h2 : 4'h1);
            irq_request = 8'h00;
        end
        stack_full = 1'b0;
        irq_request = 8'h04;
        halt(1'b1, 1'b0, MODE_IDLE_FAST_ONLY_MODE);
        tick(20);
        chk_val(cpu_halted, 1'b1);
        irq_request = 8'h0c;
        wait_run(4'h2);
        irq_request = 8'h00;
        $display("test interrupt wake done");
        halt(1'b0, 1'b0, MODE_SLEEP);
        watchdog_overflow = 1'b1;
        tick(1);
        watchdog_overflow = 1'b0;
        wait_run(4'h4);
        chk_val({watchdog_timeout_flag, power_down_flag}, 2'h3);
        clear_watchdog = 1'b1;
        tick(1);
        clear_watchdog = 1'b0;
        tick(2);
        chk_val(power_down_flag, 1'b0);
        halt(1'b0, 1'b1, MODE_IDLE_SUB_ONLY_MODE);
        external_reset_req = 1'b1;
        wait_run(4'h8);
        external_reset_req = 1'b0;
        $display("test watchdog and reset wake done");
        tick(5);
        final_report();
    end
endmodule : power_mode_controller_tb
